// ===== src/addr_decode_defs.svh
// Purpose: Named constants for the chip-select decoder
// Assumes: Address top bits A23..A21 presented as a 3-bit field
// Notes: Region codes of the memory map
`ifndef ADDR_DECODE_DEFS_SVH
`define ADDR_DECODE_DEFS_SVH
`define REGION_BOOT_ROM 3'h0
`define REGION_SECOND_ROM 3'h1
`define REGION_RAM_0 3'h2
`define REGION_RAM_1 3'h3
`define REGION_RAM_2 3'h4
`define REGION_RAM_3 3'h5
`define REGION_UNMAPPED_0 3'h6
`define REGION_UNMAPPED_1 3'h7
`define INIT_RESET_VALUE 1'h1
`define SELECTS_IDLE 3'h7
`endif

// ===== src/addr_decode_pkg.sv
// Purpose: Types shared by the decoder files
// Assumes: Nothing beyond the constants header
// Notes: Select bundle is active low per bit
package addr_decode_pkg;
  typedef struct packed {
    logic bootRomSelectN;
    logic secondRomSelectN;
    logic ramSelectN;
  } selects_t;
  typedef struct packed {
    logic initLevel;
  } switch_state_t;
  typedef struct packed {
    selects_t sel;
    logic initOut;
  } decode_state_t;
endpackage : addr_decode_pkg

// ===== src/switch_init_latch.sv
// Purpose: Debounce latch for the two-contact reset switch
// Assumes: Contact inputs active low, synchronous to mclk
// Notes: Holds last contact reached, ignores travel and bounce
`timescale 1ns/1ps
`include "addr_decode_defs.svh"
module switch_init_latch (
  // Clock and control
  input wire logic mclk,
  input wire logic reset,
  input wire logic clockEnable,
  // Switch contacts
  input wire logic upperContactN,
  input wire logic lowerContactN,
  // Result
  output logic initLevel
);
  addr_decode_pkg::switch_state_t state;
  addr_decode_pkg::switch_state_t next_state;

  // Set/reset behaviour: lower contact clears, upper contact sets
  always_comb begin
    next_state = state;
    if (!lowerContactN) begin
      next_state.initLevel = 1'h0;
    end else if (!upperContactN) begin
      next_state.initLevel = 1'h1;
    end
    // Neither contact: keep value, travel and bounce ignored
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state.initLevel <= `INIT_RESET_VALUE;
    end else if (clockEnable) begin
      state <= next_state;
    end
  end

  assign initLevel = state.initLevel;

  a_init_falls_low: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && !lowerContactN |=> !initLevel)
    else $error("init did not fall on lower contact");
  a_init_holds_travel: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && lowerContactN && upperContactN |=> initLevel == $past(initLevel))
    else $error("init changed while switch travelled");
  a_init_rises_upper: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && !upperContactN && lowerContactN |=> initLevel)
    else $error("init not high at upper contact");
endmodule : switch_init_latch

// ===== src/address_decode_with_switch_init.sv
// Purpose: Chip-select decoder with debounced init from a reset switch
// Assumes: Bus inputs synchronous to mclk; selects registered one cycle
// Notes: Selects and init come straight from flip-flops
`timescale 1ns/1ps
`include "addr_decode_defs.svh"
module address_decode_with_switch_init (
  // Clock and control
  input wire logic mclk,
  input wire logic reset,
  input wire logic clockEnable,
  // Bus master side
  input wire logic [2:0] addrHigh,
  input wire logic addr_strobe_n,
  input wire logic readNotWrite,
  // Reset switch contacts
  input wire logic upperContactN,
  input wire logic lowerContactN,
  // Memory selects and init
  output addr_decode_pkg::selects_t selects,
  output logic initOut
);
  addr_decode_pkg::decode_state_t state;
  addr_decode_pkg::decode_state_t next_state;
  logic initLevel;
  logic qualified;

  // Debounce latch, init fed back into the decode
  switch_init_latch latch (
    .mclk(mclk),
    .reset(reset),
    .clockEnable(clockEnable),
    .upperContactN(upperContactN),
    .lowerContactN(lowerContactN),
    .initLevel(initLevel)
  );

  // Strobe and init qualify every select; master keeps strobe honest
  assign qualified = !addr_strobe_n && initLevel;

  // Region decode; unmapped regions fall to the idle default
  always_comb begin
    next_state = state;
    next_state.sel = `SELECTS_IDLE;
    next_state.initOut = initLevel;
    if (qualified) begin
      case (addrHigh)
        `REGION_BOOT_ROM: begin
          next_state.sel.bootRomSelectN = !readNotWrite;
        end
        `REGION_SECOND_ROM: begin
          next_state.sel.secondRomSelectN = !readNotWrite;
        end
        `REGION_RAM_0, `REGION_RAM_1, `REGION_RAM_2, `REGION_RAM_3: begin
          next_state.sel.ramSelectN = 1'h0;
        end
        default: begin
          next_state.sel = `SELECTS_IDLE;
        end
      endcase
    end
  end

  // Registered outputs: one cycle from bus inputs to pins, two from the switch contacts, a small added latency
  always_ff @(posedge mclk) begin
    if (reset) begin
      state.sel <= `SELECTS_IDLE;
      state.initOut <= `INIT_RESET_VALUE;
    end else if (clockEnable) begin
      state <= next_state;
    end
  end

  assign selects = state.sel;
  assign initOut = state.initOut;

  a_boot_rom_decode: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && addrHigh == `REGION_BOOT_ROM && initLevel && !addr_strobe_n
    && readNotWrite |=> !selects.bootRomSelectN)
    else $error("boot rom select missing");
  a_second_rom_decode: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && addrHigh == `REGION_SECOND_ROM && initLevel && !addr_strobe_n
    && readNotWrite |=> !selects.secondRomSelectN)
    else $error("second rom select missing");
  a_ram_decode: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && addrHigh >= `REGION_RAM_0 && addrHigh <= `REGION_RAM_3 && initLevel
    && !addr_strobe_n |=> !selects.ramSelectN)
    else $error("ram select missing");
  a_rom_write_block: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && !readNotWrite |=> selects.bootRomSelectN && selects.secondRomSelectN)
    else $error("rom selected on write");
  a_strobe_gate: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && addr_strobe_n |=> selects == `SELECTS_IDLE)
    else $error("select without strobe");
  a_init_block: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && !initLevel |=> selects == `SELECTS_IDLE)
    else $error("select during init");
  a_init_output: assert property (@(posedge mclk) disable iff (reset)
    clockEnable |=> initOut == $past(initLevel))
    else $error("init output mismatch");
  a_unmapped_idle: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && addrHigh[2] && addrHigh[1] |=> selects == `SELECTS_IDLE)
    else $error("select in unmapped region");
  a_one_select: assert property (@(posedge mclk) disable iff (reset)
    $countones(~selects) <= 1)
    else $error("more than one select");

  // Independent region view for the checks below, one hit bit per code
  localparam int REGION_COUNT = 2 ** $bits(addrHigh);
  logic [REGION_COUNT-1:0] regionHit;
  logic ramRegion;
  logic unmappedRegion;

  for (genvar r = 0; r < REGION_COUNT; r++) begin : g_region
    assign regionHit[r] = (addrHigh == 3'(r));
  end

  // Grouped regions, kept apart from the case so a decode slip shows up
  assign ramRegion = regionHit[`REGION_RAM_0] | regionHit[`REGION_RAM_1]
    | regionHit[`REGION_RAM_2] | regionHit[`REGION_RAM_3];
  assign unmappedRegion = regionHit[`REGION_UNMAPPED_0] | regionHit[`REGION_UNMAPPED_1];

  // Boot ROM select only for a qualified read of its region
  a_boot_rom_only: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && !(regionHit[`REGION_BOOT_ROM] && initLevel && !addr_strobe_n
    && readNotWrite) |=> selects.bootRomSelectN)
    else $error("boot rom select without its terms");

  // Second ROM select only for a qualified read of its region
  a_second_rom_only: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && !(regionHit[`REGION_SECOND_ROM] && initLevel && !addr_strobe_n
    && readNotWrite) |=> selects.secondRomSelectN)
    else $error("second rom select without its terms");

  // RAM select only for a qualified access of a RAM region
  a_ram_only: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && !(ramRegion && initLevel && !addr_strobe_n) |=> selects.ramSelectN)
    else $error("ram select without its terms");

  // RAM answers reads
  a_ram_read_decode: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && ramRegion && initLevel && !addr_strobe_n && readNotWrite
    |=> !selects.ramSelectN)
    else $error("ram select missing on read");

  // RAM answers writes as well
  a_ram_write_decode: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && ramRegion && initLevel && !addr_strobe_n && !readNotWrite
    |=> !selects.ramSelectN)
    else $error("ram select missing on write");

  // Boot ROM is read-only
  a_boot_rom_write: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && regionHit[`REGION_BOOT_ROM] && !readNotWrite |=> selects.bootRomSelectN)
    else $error("boot rom selected on write");

  // Second ROM is read-only
  a_second_rom_write: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && regionHit[`REGION_SECOND_ROM] && !readNotWrite
    |=> selects.secondRomSelectN)
    else $error("second rom selected on write");

  // No strobe, no boot ROM select
  a_boot_strobe_gate: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && addr_strobe_n |=> selects.bootRomSelectN)
    else $error("boot rom select without strobe");

  // No strobe, no second ROM select
  a_second_strobe_gate: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && addr_strobe_n |=> selects.secondRomSelectN)
    else $error("second rom select without strobe");

  // No strobe, no RAM select
  a_ram_strobe_gate: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && addr_strobe_n |=> selects.ramSelectN)
    else $error("ram select without strobe");

  // Low init blocks the boot ROM
  a_boot_init_gate: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && !initLevel |=> selects.bootRomSelectN)
    else $error("boot rom select during init");

  // Low init blocks the second ROM
  a_second_init_gate: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && !initLevel |=> selects.secondRomSelectN)
    else $error("second rom select during init");

  // Low init blocks the RAM
  a_ram_init_gate: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && !initLevel |=> selects.ramSelectN)
    else $error("ram select during init");

  // Unmapped space never reaches the boot ROM
  a_unmapped_boot: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && unmappedRegion |=> selects.bootRomSelectN)
    else $error("boot rom select in unmapped space");

  // Unmapped space never reaches the second ROM
  a_unmapped_second: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && unmappedRegion |=> selects.secondRomSelectN)
    else $error("second rom select in unmapped space");

  // Unmapped space never reaches the RAM
  a_unmapped_ram: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && unmappedRegion |=> selects.ramSelectN)
    else $error("ram select in unmapped space");

  // First unmapped code leaves every select idle
  a_region_six_idle: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && regionHit[`REGION_UNMAPPED_0] |=> selects == `SELECTS_IDLE)
    else $error("select in first unmapped region");

  // Second unmapped code leaves every select idle
  a_region_seven_idle: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && regionHit[`REGION_UNMAPPED_1] |=> selects == `SELECTS_IDLE)
    else $error("select in second unmapped region");

  // Boot region never selects the RAM
  a_boot_not_ram: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && regionHit[`REGION_BOOT_ROM] |=> selects.ramSelectN)
    else $error("ram select in boot region");

  // Second ROM region never selects the RAM
  a_second_not_ram: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && regionHit[`REGION_SECOND_ROM] |=> selects.ramSelectN)
    else $error("ram select in second rom region");

  // RAM regions never select the boot ROM
  a_ram_not_boot: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && ramRegion |=> selects.bootRomSelectN)
    else $error("boot rom select in ram region");

  // RAM regions never select the second ROM
  a_ram_not_second: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && ramRegion |=> selects.secondRomSelectN)
    else $error("second rom select in ram region");

  // Boot region never selects the second ROM
  a_boot_not_second: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && regionHit[`REGION_BOOT_ROM] |=> selects.secondRomSelectN)
    else $error("second rom select in boot region");

  // Second ROM region never selects the boot ROM
  a_second_not_boot: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && regionHit[`REGION_SECOND_ROM] |=> selects.bootRomSelectN)
    else $error("boot rom select in second rom region");

  // Pin follows the latch two enabled edges after the lower contact
  a_init_out_falls: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && !lowerContactN ##1 clockEnable |=> !initOut)
    else $error("init output did not fall");

  // Pin returns high two enabled edges after the upper contact
  a_init_out_rises: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && !upperContactN && lowerContactN ##1 clockEnable |=> initOut)
    else $error("init output did not rise");

  // Travel between contacts leaves the pin alone
  a_init_out_travel: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && lowerContactN && upperContactN ##1 clockEnable
    |=> initOut == $past(initOut))
    else $error("init output moved during travel");

  // Once low, the pin stays low until the upper contact
  a_init_low_hold: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && !initLevel && upperContactN ##1 clockEnable |=> !initOut)
    else $error("init output released early");

  // Pin and selects register the same latch value, so low pin means idle
  a_init_out_blocks: assert property (@(posedge mclk) disable iff (reset)
    !initOut |-> selects == `SELECTS_IDLE)
    else $error("select while init output low");

  // Latch stays high unless the lower contact is reached
  a_latch_holds_high: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && initLevel && lowerContactN |=> initLevel)
    else $error("init fell without lower contact");

  // Latch stays low unless the upper contact is reached
  a_latch_holds_low: assert property (@(posedge mclk) disable iff (reset)
    clockEnable && !initLevel && upperContactN |=> !initLevel)
    else $error("init rose without upper contact");

  // Disabled clock freezes the selects
  a_freeze_selects: assert property (@(posedge mclk) disable iff (reset)
    !clockEnable |=> $stable(selects))
    else $error("selects moved while frozen");

  // Disabled clock freezes the init output
  a_freeze_init: assert property (@(posedge mclk) disable iff (reset)
    !clockEnable |=> $stable(initOut))
    else $error("init output moved while frozen");

  // Reset leaves every select idle
  a_reset_selects: assert property (@(posedge mclk)
    reset |=> selects == `SELECTS_IDLE)
    else $error("selects not idle after reset");

  // Reset leaves the init output high
  a_reset_init: assert property (@(posedge mclk)
    reset |=> initOut)
    else $error("init output not high after reset");
endmodule : address_decode_with_switch_init

// ===== sim/reset_switch_model.sv
// Purpose: Two-contact reset switch at the decoder's far side
// Assumes: pos 0 rests up, 1 travels, 2 bounces near the bottom, 3 rests down
// Notes: Bounce chatters every cycle to tempt the latch
`timescale 1ns/1ps
module reset_switch_model (
  // Clock
  input wire logic mclk,
  // Position command
  input wire logic [1:0] pos,
  // Contacts, low while touched
  output logic upperContactN,
  output logic lowerContactN
);
  logic flick = 1'h0;
  // Chatter source for the bounce position
  always @(posedge mclk) begin
    flick <= ~flick;
  end
  // Never both contacts at once
  assign upperContactN = (pos != 2'h0);
  assign lowerContactN = (pos == 2'h3) ? 1'h0 : ((pos == 2'h2) ? flick : 1'h1);
endmodule : reset_switch_model

// ===== sim/address_decode_with_switch_init_tb_top.sv
// Purpose: Self-checking bench for the select decoder and switch latch
// Assumes: One cycle from sampled bus inputs to outputs, two from the switch contacts
// Notes: Expectations track the latch as it was before each edge
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module address_decode_with_switch_init_tb_top;
  logic mclk = 1'h0;
  logic reset = 1'h1;
  logic clockEnable = 1'h1;
  logic [2:0] addrHigh = 3'h0;
  logic addr_strobe_n = 1'h1;
  logic readNotWrite = 1'h1;
  logic [1:0] pos = 2'h0;
  logic upperContactN, lowerContactN, initOut;
  addr_decode_pkg::selects_t selects;
  logic [2:0] expSel = 3'h7;
  logic expInit = 1'h1;
  logic latch = 1'h1;
  logic [31:0] seed = 32'h00014BBD;
  logic [1:0] seq [10] = '{2'h1, 2'h2, 2'h3, 2'h2, 2'h1, 2'h2, 2'h1, 2'h0, 2'h1, 2'h0};
  int n_fail = 0;
  int n_tests = 0;
  // Free-running clock
  always #4 mclk = ~mclk;
  address_decode_with_switch_init uut (.mclk(mclk), .reset(reset), .clockEnable(clockEnable),
    .addrHigh(addrHigh), .addr_strobe_n(addr_strobe_n), .readNotWrite(readNotWrite),
    .upperContactN(upperContactN), .lowerContactN(lowerContactN), .selects(selects),
    .initOut(initOut));
  reset_switch_model sw (.mclk(mclk), .pos(pos), .upperContactN(upperContactN),
    .lowerContactN(lowerContactN));
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  // Expected selects from the bus inputs and the latch before the edge
  function automatic logic [2:0] dec(logic [2:0] a, logic s, logic rw, logic i);
    dec = 3'h7;
    if (!s && i) begin
      dec[2] = !(a == 3'h0 && rw);
      dec[1] = !(a == 3'h1 && rw);
      dec[0] = !(a >= 3'h2 && a <= 3'h5);
    end
  endfunction : dec
  task end_sim();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  // Check the last cycle, then drive and predict the next one
  task cyc(input logic [2:0] a, input logic s, rw, ce, rs, input logic [1:0] p);
    @(posedge mclk);
    #1;
    `CHK("bootRomSelectN", expSel[2], selects.bootRomSelectN)
    `CHK("secondRomSelectN", expSel[1], selects.secondRomSelectN)
    `CHK("ramSelectN", expSel[0], selects.ramSelectN)
    `CHK("initOut", expInit, initOut)
    reset = rs;
    clockEnable = ce;
    addrHigh = a;
    addr_strobe_n = s;
    readNotWrite = rw;
    pos = p;
    #1;
    if (rs) begin
      latch = 1'h1;
      expSel = 3'h7;
      expInit = 1'h1;
    end else if (ce) begin
      expSel = dec(a, s, rw, latch);
      expInit = latch;
      latch = !lowerContactN ? 1'h0 : (!upperContactN ? 1'h1 : latch);
    end
  endtask : cyc
  // Hang guard well past the planned run
  initial begin
    #40000;
    n_fail++;
    end_sim();
  end
  initial begin
    for (int i = 0; i < 20; i++) cyc(3'h0, 1'h1, 1'h1, 1'h1, 1'h1, 2'h0);
    // Every region, both directions, strobe on and off
    for (int k = 0; k < 32; k++) cyc(k[2:0], k[4], k[3], 1'h1, 1'h0, 2'h0);
    // Travel, bounce and rest while reading the boot region
    for (int j = 0; j < 10; j++) cyc(3'h0, 1'h0, 1'h1, 1'h1, 1'h0, seq[j]);
    for (int n = 0; n < 1500; n++) begin
      seed = xs(seed);
      cyc(seed[2:0], seed[3], seed[4], seed[7:5] != 3'h0, seed[15:8] == 8'h00,
        (seed[19:18] == 2'h3) ? seed[17:16] : 2'h0);
    end
    end_sim();
  end
endmodule : address_decode_with_switch_init_tb_top
